// ===== otf_cfg.svh
// Constants for the output terminal function select block
`ifndef OTF_CFG_SVH
`define OTF_CFG_SVH
// Digital output selection codes
`define OTF_DO_POWERON   6'h18
`define OTF_DO_FDT2      6'h19
`define OTF_DO_TIMED     6'h1e
`define OTF_DO_AI1_OUT   6'h1f
`define OTF_DO_OFFLOAD   6'h20
`define OTF_DO_REVERSE   6'h21
`define OTF_DO_MODTEMP   6'h23
`define OTF_DO_LOWLIM    6'h25
`define OTF_DO_ALARM     6'h26
`define OTF_DO_RUNTIME   6'h27
`define OTF_DO_FAULT     6'h28
`define OTF_DO_AI1_LO    6'h29
`define OTF_DO_AI1_HI    6'h2a
`define OTF_DO_AI2_LO    6'h2b
`define OTF_DO_AI2_HI    6'h2c
// Quantity selections and their reset values
`define OTF_Q_MAX        5'h10
`define OTF_RST_DO_SEL   6'h00
`define OTF_RST_FMP_SEL  5'h00
`define OTF_RST_AO1_SEL  5'h00
`define OTF_RST_AO2_SEL  5'h01
// Full scales of the quantities
`define OTF_AI_FULL      16'h2710
`define OTF_PULSE_FULL   16'h2710
`define OTF_COMM_FULL    16'h03e8
`define OTF_TENTH_FULL   16'h2710
`define OTF_VFS_MUL      20'h00006
`define OTF_VFS_DIV      20'h00005
`define OTF_CODE_FULL    16'hffff
// Analog spans in mV and uA
`define OTF_SPAN_MV      16'h2710
`define OTF_SPAN_UA      16'h4e20
// Pulse output in 0.01 kHz units
`define OTF_FMP_MIN      16'h0001
`define OTF_FMP_MAX      16'h2710
`define OTF_FMP_UNIT_HZ  10
`define OTF_CLK_HZ       250000000
// Hysteresis in tenths of a percent
`define OTF_HYST_SCALE   10'h3e8
`endif

// ===== otf_pkg.sv
// Types for the output terminal function select block
`default_nettype none
package otf_pkg;
  typedef logic [15:0] otf_val_t;
  typedef logic signed [15:0] otf_sval_t;
  typedef logic [5:0] otf_dosel_t;
  typedef logic [4:0] otf_qsel_t;
  typedef struct packed {
    logic [19:0] num;
    logic [19:0] den;
  } otf_frac_t;
  typedef enum logic {OTF_DIV_IDLE, OTF_DIV_RUN} otf_div_st_t;
endpackage
`default_nettype wire

// ===== otf_scale.sv
// Iterative divider giving a quantity as a fraction of full scale
`include "otf_cfg.svh"
`default_nettype none
module otf_scale #(
  parameter int NW = 20,
  parameter int CW = 16
) (
  input  wire logic          sys_clk,
  input  wire logic          arst_n,
  input  wire logic [NW-1:0] num,
  input  wire logic [NW-1:0] den,
  output logic      [CW-1:0] code,
  output logic               done
);
  import otf_pkg::*;
  otf_div_st_t   st_reg;
  logic [NW:0]   rem_reg;
  logic [NW:0]   rem_sh;
  logic [NW-1:0] den_reg;
  logic [CW-1:0] q_reg;
  logic [4:0]    cnt_reg;
  logic          clamp;
  assign clamp  = (den == '0) || (num >= den);
  assign rem_sh = {rem_reg[NW-1:0], 1'b0};
  // ------------------------------------------------------------
  // Division steps
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg  <= OTF_DIV_IDLE;
      rem_reg <= '0;
      den_reg <= '0;
      q_reg   <= '0;
      cnt_reg <= 5'h00;
      code    <= '0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (st_reg)
        OTF_DIV_IDLE: begin
          if (clamp) begin
            code <= `OTF_CODE_FULL;
            done <= 1'b1;
          end else begin
            rem_reg <= {1'b0, num};
            den_reg <= den;
            q_reg   <= '0;
            cnt_reg <= 5'h00;
            st_reg  <= OTF_DIV_RUN;
          end
        end
        OTF_DIV_RUN: begin
          rem_reg <= (rem_sh >= {1'b0, den_reg}) ?
                     rem_sh - {1'b0, den_reg} : rem_sh;
          q_reg   <= {q_reg[CW-2:0], rem_sh >= {1'b0, den_reg}};
          cnt_reg <= cnt_reg + 5'h01;
          if (cnt_reg == 5'(CW-1)) begin
            code   <= {q_reg[CW-2:0], rem_sh >= {1'b0, den_reg}};
            done   <= 1'b1;
            st_reg <= OTF_DIV_IDLE;
          end
        end
      endcase
    end
  end
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_clamp;
    @(posedge sys_clk) disable iff (!arst_n)
    (st_reg == OTF_DIV_IDLE) && clamp |=> done && (code == '1);
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp missed");
  property p_div_len;
    @(posedge sys_clk) disable iff (!arst_n)
    (st_reg == OTF_DIV_IDLE) && !clamp |=> !done [*8] ##9 done;
  endproperty
  a_div_len: assert property (p_div_len) else $error("divide length");
  c_div: cover property (@(posedge sys_clk) st_reg == OTF_DIV_RUN ##1
                          st_reg == OTF_DIV_IDLE);
endmodule
`default_nettype wire

// ===== otf_hyst.sv
// Frequency level detector with release hysteresis
`include "otf_cfg.svh"
`default_nettype none
module otf_hyst (
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire otf_pkg::otf_val_t freq,
  input  wire otf_pkg::otf_val_t level,
  input  wire logic [9:0]       hyst,
  output logic                  det
);
  import otf_pkg::*;
  logic [9:0]  keep;
  logic        below;
  assign keep  = (hyst > `OTF_HYST_SCALE) ? 10'h000
               : `OTF_HYST_SCALE - hyst;
  assign below = (26'(freq) * 26'(`OTF_HYST_SCALE)) <
                 (26'(level) * 26'(keep));
  // ------------------------------------------------------------
  // Detector
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      det <= 1'b0;
    end else if (freq > level) begin
      det <= 1'b1;
    end else if (below) begin
      det <= 1'b0;
    end
  end
  property p_set;
    @(posedge sys_clk) disable iff (!arst_n) freq > level |=> det;
  endproperty
  a_set: assert property (p_set) else $error("no set");
  property p_hold;
    @(posedge sys_clk) disable iff (!arst_n) det && !below |=> det;
  endproperty
  a_hold: assert property (p_hold) else $error("early drop");
  c_det: cover property (@(posedge sys_clk) !det ##1 det);
endmodule
`default_nettype wire

// ===== otf_top.sv
// Output terminal function select: digital, pulse and analog outputs
`include "otf_cfg.svh"
`default_nettype none
module otf_top (
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  input  wire logic              sel_load,
  input  wire otf_pkg::otf_dosel_t do_sel_in,
  input  wire otf_pkg::otf_qsel_t fmp_sel_in,
  input  wire otf_pkg::otf_qsel_t ao1_sel_in,
  input  wire otf_pkg::otf_qsel_t ao2_sel_in,
  input  wire logic              ao1_current_mode,
  input  wire logic              ao2_current_mode,
  input  wire otf_pkg::otf_val_t power_on_time_monitor,
  input  wire otf_pkg::otf_val_t power_on_time_threshold,
  input  wire logic              timing_function_select,
  input  wire otf_pkg::otf_val_t cur_run_time,
  input  wire otf_pkg::otf_val_t timing_duration,
  input  wire otf_pkg::otf_val_t start_elapsed_time,
  input  wire otf_pkg::otf_val_t run_time_threshold,
  input  wire otf_pkg::otf_val_t analog_in_one,
  input  wire otf_pkg::otf_val_t analog_in_two,
  input  wire otf_pkg::otf_val_t analog_in_three,
  input  wire otf_pkg::otf_val_t ai_lower_protect_limit,
  input  wire otf_pkg::otf_val_t ai_upper_protect_limit,
  input  wire logic              off_load,
  input  wire logic              run_reverse,
  input  wire otf_pkg::otf_val_t heatsink_temp_monitor,
  input  wire otf_pkg::otf_val_t module_temp_threshold,
  input  wire otf_pkg::otf_val_t run_freq,
  input  wire otf_pkg::otf_val_t set_freq,
  input  wire otf_pkg::otf_val_t max_freq,
  input  wire otf_pkg::otf_val_t lower_limit_freq,
  input  wire logic              drive_stopped,
  input  wire logic              fault_active,
  input  wire logic              fault_continue,
  input  wire logic              undervoltage,
  input  wire otf_pkg::otf_val_t fdt2_level,
  input  wire logic [9:0]        fdt2_hyst,
  input  wire otf_pkg::otf_val_t motor_current,
  input  wire otf_pkg::otf_val_t rated_current,
  input  wire otf_pkg::otf_val_t torque_abs,
  input  wire otf_pkg::otf_sval_t torque_act,
  input  wire otf_pkg::otf_val_t rated_torque,
  input  wire otf_pkg::otf_val_t out_power,
  input  wire otf_pkg::otf_val_t rated_power,
  input  wire otf_pkg::otf_val_t out_voltage,
  input  wire otf_pkg::otf_val_t rated_voltage,
  input  wire otf_pkg::otf_val_t pulse_in_freq,
  input  wire otf_pkg::otf_val_t cur_length,
  input  wire otf_pkg::otf_val_t max_length,
  input  wire otf_pkg::otf_val_t cur_count,
  input  wire otf_pkg::otf_val_t max_count,
  input  wire otf_pkg::otf_val_t comm_setting,
  input  wire otf_pkg::otf_val_t current_tenth_amp,
  input  wire otf_pkg::otf_val_t voltage_tenth_volt,
  input  wire otf_pkg::otf_val_t pulse_output_max_freq,
  output logic                   digital_out,
  output logic                   freq_level_detect_two,
  output logic                   pulse_freq_output,
  output otf_pkg::otf_val_t      pulse_freq_units,
  output otf_pkg::otf_val_t      analog_out_one,
  output otf_pkg::otf_val_t      analog_out_two
);
  import otf_pkg::*;
  localparam logic [31:0] FMP_STEP =
    32'((64'(`OTF_FMP_UNIT_HZ) << 32) / 64'(`OTF_CLK_HZ));

  otf_dosel_t do_sel_reg;
  otf_qsel_t  q_sel_reg [3];
  otf_qsel_t  q_sel_in  [3];
  otf_frac_t  frac      [3];
  otf_val_t   code      [3];
  logic [2:0] done;
  logic       do_next;
  logic       ai1_low;
  logic       ai1_high;
  otf_val_t   fmp_max;
  logic [31:0] phase_reg;

  assign q_sel_in[0] = fmp_sel_in;
  assign q_sel_in[1] = ao1_sel_in;
  assign q_sel_in[2] = ao2_sel_in;

  // ------------------------------------------------------------
  // Quantity decoding, shared by the three channels
  // ------------------------------------------------------------
  function automatic otf_frac_t pick(input otf_qsel_t sel);
    otf_frac_t  f;
    logic signed [20:0] t;
    f = '{num: 20'h00000, den: 20'h00001};
    t = 21'(torque_act) + 21'({rated_torque, 1'b0});
    unique case (sel)
      5'h00, 5'h0d: f = '{20'(run_freq), 20'(max_freq)};
      5'h01: f = '{20'(set_freq), 20'(max_freq)};
      5'h02: f = '{20'(motor_current),
                   20'({rated_current, 1'b0})};
      5'h03: f = '{20'(torque_abs),
                   20'({rated_torque, 1'b0})};
      5'h04: f = '{20'(out_power),
                   20'({rated_power, 1'b0})};
      5'h05: f = '{20'(out_voltage) * `OTF_VFS_DIV,
                   20'(rated_voltage) * `OTF_VFS_MUL};
      5'h06: f = '{20'(pulse_in_freq), 20'(`OTF_PULSE_FULL)};
      5'h07: f = '{20'(analog_in_one), 20'(`OTF_AI_FULL)};
      5'h08: f = '{20'(analog_in_two), 20'(`OTF_AI_FULL)};
      5'h09: f = '{20'(analog_in_three), 20'(`OTF_AI_FULL)};
      5'h0a: f = '{20'(cur_length), 20'(max_length)};
      5'h0b: f = '{20'(cur_count), 20'(max_count)};
      5'h0c: f = '{20'(comm_setting), 20'(`OTF_COMM_FULL)};
      5'h0e: f = '{20'(current_tenth_amp),
                   20'(`OTF_TENTH_FULL)};
      5'h0f: f = '{20'(voltage_tenth_volt),
                   20'(`OTF_TENTH_FULL)};
      5'h10: f = '{(t < 0) ? 20'h00000 : t[19:0],
                   20'({rated_torque, 2'b00})};
      default: f = '{20'h00000, 20'h00001};
    endcase
    return f;
  endfunction

  // ------------------------------------------------------------
  // Selection registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      do_sel_reg <= `OTF_RST_DO_SEL;
    end else if (sel_load) begin
      do_sel_reg <= do_sel_in;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q_sel_reg[0] <= `OTF_RST_FMP_SEL;
      q_sel_reg[1] <= `OTF_RST_AO1_SEL;
      q_sel_reg[2] <= `OTF_RST_AO2_SEL;
    end else if (sel_load) begin
      for (int i = 0; i < 3; i++) begin
        if (q_sel_in[i] <= `OTF_Q_MAX) begin
          q_sel_reg[i] <= q_sel_in[i];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Scaling channels
  // ------------------------------------------------------------
  // Process, not assign: pick reads inputs beyond its argument
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      frac[i] = pick(q_sel_reg[i]);
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_ch
    otf_scale #(.NW(20), .CW(16)) u_scale (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .num     (frac[g].num),
      .den     (frac[g].den),
      .code    (code[g]),
      .done    (done[g])
    );
  end

  // ------------------------------------------------------------
  // Frequency level detector two
  // ------------------------------------------------------------
  otf_hyst u_fdt2 (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .freq    (run_freq),
    .level   (fdt2_level),
    .hyst    (fdt2_hyst),
    .det     (freq_level_detect_two)
  );

  // ------------------------------------------------------------
  // Digital output condition
  // ------------------------------------------------------------
  assign ai1_low  = analog_in_one < ai_lower_protect_limit;
  assign ai1_high = analog_in_one > ai_upper_protect_limit;

  always_comb begin
    do_next = 1'b0;
    unique case (do_sel_reg)
      `OTF_DO_POWERON: do_next = power_on_time_monitor >
                                 power_on_time_threshold;
      `OTF_DO_FDT2:    do_next = freq_level_detect_two;
      `OTF_DO_TIMED:   do_next = timing_function_select &&
                                 (cur_run_time >=
                                  timing_duration);
      `OTF_DO_AI1_OUT: do_next = ai1_low || ai1_high;
      `OTF_DO_OFFLOAD: do_next = off_load;
      `OTF_DO_REVERSE: do_next = run_reverse;
      `OTF_DO_MODTEMP: do_next = heatsink_temp_monitor >=
                                 module_temp_threshold;
      `OTF_DO_LOWLIM:  do_next = drive_stopped ||
                                 (run_freq <=
                                  lower_limit_freq);
      `OTF_DO_ALARM:   do_next = fault_active &&
                                 fault_continue;
      `OTF_DO_RUNTIME: do_next = start_elapsed_time >
                                 run_time_threshold;
      `OTF_DO_FAULT:   do_next = fault_active &&
                                 !undervoltage;
      `OTF_DO_AI1_LO:  do_next = ai1_low;
      `OTF_DO_AI1_HI:  do_next = ai1_high;
      `OTF_DO_AI2_LO:  do_next = analog_in_two <
                                 ai_lower_protect_limit;
      `OTF_DO_AI2_HI:  do_next = analog_in_two >
                                 ai_upper_protect_limit;
      default:         do_next = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      digital_out <= 1'b0;
    end else begin
      digital_out <= do_next;
    end
  end

  // ------------------------------------------------------------
  // Pulse frequency output
  // ------------------------------------------------------------
  assign fmp_max = (pulse_output_max_freq < `OTF_FMP_MIN) ? `OTF_FMP_MIN
                 : (pulse_output_max_freq > `OTF_FMP_MAX) ? `OTF_FMP_MAX
                 : pulse_output_max_freq;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_freq_units <= `OTF_FMP_MIN;
    end else if (done[0]) begin
      pulse_freq_units <= `OTF_FMP_MIN +
        16'((32'(code[0]) * 32'(fmp_max - `OTF_FMP_MIN)) >> 16);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg         <= 32'h00000000;
      pulse_freq_output <= 1'b0;
    end else begin
      phase_reg         <= phase_reg +
                           32'(32'(pulse_freq_units) * FMP_STEP);
      pulse_freq_output <= phase_reg[31];
    end
  end

  // ------------------------------------------------------------
  // Analog outputs in mV or uA
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      analog_out_one <= 16'h0000;
    end else if (done[1]) begin
      analog_out_one <= 16'((32'(code[1]) * 32'(ao1_current_mode ?
        `OTF_SPAN_UA : `OTF_SPAN_MV)) >> 16);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      analog_out_two <= 16'h0000;
    end else if (done[2]) begin
      analog_out_two <= 16'((32'(code[2]) * 32'(ao2_current_mode ?
        `OTF_SPAN_UA : `OTF_SPAN_MV)) >> 16);
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  property p_poweron;
    do_sel_reg == 6'h18 && power_on_time_monitor > power_on_time_threshold
      |=> digital_out;
  endproperty
  a_poweron: assert property (p_poweron) else $error("code 24");
  property p_timed;
    do_sel_reg == 6'h1e && !timing_function_select |=> !digital_out;
  endproperty
  a_timed: assert property (p_timed) else $error("code 30");
  property p_band;
    do_sel_reg == 6'h1f |=> digital_out == $past(ai1_low || ai1_high);
  endproperty
  a_band: assert property (p_band) else $error("code 31");
  property p_rev;
    do_sel_reg == 6'h21 |=> digital_out == $past(run_reverse);
  endproperty
  a_rev: assert property (p_rev) else $error("code 33");
  property p_lowlim;
    do_sel_reg == 6'h25 && drive_stopped |=> digital_out;
  endproperty
  a_lowlim: assert property (p_lowlim) else $error("code 37");
  property p_uv;
    do_sel_reg == 6'h28 && undervoltage |=> !digital_out;
  endproperty
  a_uv: assert property (p_uv) else $error("code 40");
  property p_reserved;
    do_sel_reg inside {6'h15, 6'h16, 6'h17, 6'h22, 6'h2d} |=> !digital_out;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved");
  property p_sel_refuse;
    sel_load && ao1_sel_in > 5'h10 |=> $stable(q_sel_reg[1]);
  endproperty
  a_sel_refuse: assert property (p_sel_refuse) else $error("sel");
  property p_span;
    analog_out_one <= 16'h4e20 && analog_out_two <= 16'h4e20;
  endproperty
  a_span: assert property (p_span) else $error("span");
  property p_fmp;
    pulse_freq_units >= 16'h0001 && pulse_freq_units <= 16'h2710;
  endproperty
  a_fmp: assert property (p_fmp) else $error("pulse range");

  c_do_rise: cover property (!digital_out ##1 digital_out);
  c_ao1: cover property (done[1] ##1 analog_out_one != 16'h0000);
  c_fmp: cover property ($rose(pulse_freq_output));
endmodule
`default_nettype wire

// ===== otf_ext_load.sv
// Model of the equipment wired to the pulse output terminal
`default_nettype none
module otf_ext_load (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        pulse_freq_output,
  output logic      [15:0] edges
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_reg;
  // Counts rising edges seen on the terminal
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_reg <= 1'b0;
      edges    <= 16'h0000;
    end else begin
      prev_reg <= pulse_freq_output;
      if (pulse_freq_output && !prev_reg) edges <= edges + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ===== otf_top_tb.sv
// Self-checking bench for the output terminal function select block
`default_nettype none
module otf_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import otf_pkg::*;
  logic sys_clk = 1'b0, arst_n = 1'b0, sel_load = 1'b0;
  otf_dosel_t do_sel_in = 6'h00;
  otf_qsel_t fmp_sel_in = 5'h00, ao1_sel_in = 5'h00, ao2_sel_in = 5'h01;
  logic ao1_current_mode, ao2_current_mode, timing_function_select, off_load;
  logic run_reverse, drive_stopped, fault_active, fault_continue;
  logic undervoltage, digital_out, freq_level_detect_two, pulse_freq_output;
  logic [9:0] fdt2_hyst;
  logic [15:0] edges, e0;
  otf_sval_t torque_act;
  otf_val_t power_on_time_monitor, power_on_time_threshold, cur_run_time;
  otf_val_t timing_duration, start_elapsed_time, run_time_threshold;
  otf_val_t analog_in_one, analog_in_two, analog_in_three, heatsink_temp_monitor;
  otf_val_t ai_lower_protect_limit, ai_upper_protect_limit, module_temp_threshold;
  otf_val_t run_freq, set_freq, max_freq, lower_limit_freq, fdt2_level;
  otf_val_t motor_current, rated_current, torque_abs, rated_torque, out_power;
  otf_val_t rated_power, out_voltage, rated_voltage, pulse_in_freq, cur_length;
  otf_val_t max_length, cur_count, max_count, comm_setting, current_tenth_amp;
  otf_val_t voltage_tenth_volt, pulse_output_max_freq, pulse_freq_units;
  otf_val_t analog_out_one, analog_out_two;
  int seed = 50631, num_errors = 0, checks = 0;
  logic [17:0] notes[$];
  event sample_ev;
  logic [4:0] tsel[5] = '{5'h07, 5'h02, 5'h05, 5'h10, 5'h0e};
  otf_val_t tmv[5] = '{16'h1388, 16'h1388, 16'h208d, 16'h1388, 16'h09c4};
  otf_val_t fv[5] = '{16'h0384, 16'h03e9, 16'h03c0, 16'h03b5, 16'h03e8};
  logic fx[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

  otf_top dut_u (.*);
  otf_ext_load ext_u (.*);

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    #100us;
    num_errors++;
    give_verdict();
  end

  task automatic give_verdict();
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input otf_val_t seen, input otf_val_t exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic note(input logic [1:0] id, input otf_val_t exp);
    notes.push_back({id, exp});
    ->sample_ev;
  endtask
  // Scoreboard: oldest note against the output it names
  always @(sample_ev) begin
    logic [17:0] n;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      case (n[17:16])
        2'h0: check({15'h0000, digital_out}, n[15:0]);
        2'h1: check(analog_out_one, n[15:0]);
        2'h2: check(analog_out_two, n[15:0]);
        default: check(pulse_freq_units, n[15:0]);
      endcase
    end
  end
  task automatic load(input otf_dosel_t d, input otf_qsel_t f, a1, a2);
    sel_load = 1'b1;
    do_sel_in = d;
    fmp_sel_in = f;
    ao1_sel_in = a1;
    ao2_sel_in = a2;
    @(negedge sys_clk);
    sel_load = 1'b0;
  endtask
  task automatic rand_inputs();
    {power_on_time_monitor, power_on_time_threshold} = $random(seed);
    {cur_run_time, timing_duration} = $random(seed);
    {start_elapsed_time, run_time_threshold} = $random(seed);
    {analog_in_one, analog_in_two} = $random(seed);
    {analog_in_three, ai_lower_protect_limit} = $random(seed);
    {ai_upper_protect_limit, heatsink_temp_monitor} = $random(seed);
    {module_temp_threshold, run_freq} = $random(seed);
    {set_freq, max_freq} = $random(seed);
    {lower_limit_freq, fdt2_level} = $random(seed);
    {motor_current, rated_current} = $random(seed);
    {torque_abs, torque_act} = $random(seed);
    {rated_torque, out_power} = $random(seed);
    {rated_power, out_voltage} = $random(seed);
    {rated_voltage, pulse_in_freq} = $random(seed);
    {cur_length, max_length} = $random(seed);
    {cur_count, max_count} = $random(seed);
    {comm_setting, current_tenth_amp} = $random(seed);
    {voltage_tenth_volt, pulse_output_max_freq} = $random(seed);
    {fdt2_hyst, ao1_current_mode, ao2_current_mode, timing_function_select,
     off_load, run_reverse, drive_stopped, fault_active, fault_continue,
     undervoltage} = 19'($random(seed));
  endtask
  function automatic logic want_do(input otf_dosel_t c);
    otf_val_t a1, lo, hi;
    a1 = analog_in_one;
    lo = ai_lower_protect_limit;
    hi = ai_upper_protect_limit;
    case (c)
      6'h18: return power_on_time_monitor > power_on_time_threshold;
      6'h1e: return timing_function_select && cur_run_time >= timing_duration;
      6'h1f: return a1 < lo || a1 > hi;
      6'h20: return off_load;
      6'h21: return run_reverse;
      6'h23: return heatsink_temp_monitor >= module_temp_threshold;
      6'h25: return drive_stopped || run_freq <= lower_limit_freq;
      6'h26: return fault_active && fault_continue;
      6'h27: return start_elapsed_time > run_time_threshold;
      6'h28: return fault_active && !undervoltage;
      6'h29: return a1 < lo;
      6'h2a: return a1 > hi;
      6'h2b: return analog_in_two < lo;
      6'h2c: return analog_in_two > hi;
      default: return 1'b0;
    endcase
  endfunction

  initial begin
    rand_inputs();
    {ao1_current_mode, ao2_current_mode} = 2'b00;
    {run_freq, max_freq, set_freq} = {16'h1388, 16'h2710, 16'h09c4};
    repeat (4) @(negedge sys_clk);
    note(2'h3, 16'h0001);
    arst_n = 1'b1;
    repeat (40) @(negedge sys_clk);
    note(2'h1, 16'h1388);
    note(2'h2, 16'h09c4);
    for (int c = 0; c < 64; c++) begin
      load(6'(c), 5'h00, 5'h00, 5'h01);
      for (int k = 0; k < 6; k++) begin
        rand_inputs();
        @(negedge sys_clk);
        if (c != 25) note(2'h0, {15'h0000, want_do(6'(c))});
      end
    end
    load(6'h19, 5'h00, 5'h00, 5'h01);
    {fdt2_level, fdt2_hyst} = {16'h03e8, 10'h032};
    for (int j = 0; j < 5; j++) begin
      run_freq = fv[j];
      repeat (2) @(negedge sys_clk);
      check(16'(freq_level_detect_two), 16'(fx[j]));
      note(2'h0, {15'h0000, fx[j]});
    end
    {analog_in_one, motor_current, rated_current} = {16'h1388, {2{16'h03e8}}};
    {out_voltage, rated_voltage, rated_torque} = {3{16'h03e8}};
    {torque_act, current_tenth_amp} = {16'h0000, 16'h09c4};
    for (int i = 0; i < 10; i++) begin
      {ao1_current_mode, ao2_current_mode} = {i[0], ~i[0]};
      load(6'h00, 5'h00, tsel[i % 5], tsel[i % 5]);
      repeat (40) @(negedge sys_clk);
      note(2'h1, i[0] ? 16'(2 * tmv[i % 5]) : tmv[i % 5]);
      note(2'h2, i[0] ? tmv[i % 5] : 16'(2 * tmv[i % 5]));
    end
    load(6'h00, 5'h00, 5'h11, 5'h1f);
    repeat (40) @(negedge sys_clk);
    note(2'h1, 16'h1388);
    {run_freq, pulse_output_max_freq} = {16'h0000, 16'h4e20};
    max_freq = 16'h2710;
    repeat (40) @(negedge sys_clk);
    note(2'h3, 16'h0001);
    run_freq = 16'h2710;
    repeat (40) @(negedge sys_clk);
    note(2'h3, 16'h270f);
    e0 = edges;
    repeat (6000) @(negedge sys_clk);
    check({15'h0000, edges != e0}, 16'h0001);
    give_verdict();
  end
endmodule
`default_nettype wire
